// ==== rce_encoder.sv ====
// Pin control logic of the remote control encoder
`timescale 1ns/1ps
module rce_encoder
	import rce_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] button_inputs,
	input wire logic send_req,
	input wire logic rate_sel,
	input wire logic timer_sel,
	input wire logic key_in,
	input wire logic key_clk,
	input wire logic key_mode_req,
	input wire logic pin_create_req,
	input wire logic pin_done,
	output logic transmitter_power_ctl,
	output logic serial_data_out,
	output logic mode_indicator_out,
	output logic pin_locked
);
	// Input synchronisers, first stage read only by second
	logic send_s1_ff, send_s2_ff, send_s3_ff;
	logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
	wire send_rise = send_s2_ff && !send_s3_ff;
	wire pin_rise = pin_s2_ff && !pin_s3_ff;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			send_s1_ff <= 1'b0;
			send_s2_ff <= 1'b0;
			send_s3_ff <= 1'b0;
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_s3_ff <= 1'b0;
		end else begin
			send_s1_ff <= send_req;
			send_s2_ff <= send_s1_ff;
			send_s3_ff <= send_s2_ff;
			pin_s1_ff <= pin_create_req;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
		end
	end

	// Rate select caught once, the first edge after reset release
	logic rate_done_ff;
	logic rate_fast_ff;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rate_done_ff <= 1'b0;
			rate_fast_ff <= 1'b0;
		end else if (!rate_done_ff) begin
			rate_done_ff <= 1'b1;
			rate_fast_ff <= rate_sel;
		end
	end
	wire [13:0] bit_div = rate_fast_ff ? FAST_DIV : SLOW_DIV;

	// Key capture from decoder: shift on key clock rising edge while in key mode
	logic [KEY_W-1:0] key_ff;
	logic kclk_s1_ff, kclk_s2_ff, kclk_s3_ff;
	logic kd_s1_ff, kd_s2_ff;
	wire kclk_rise = kclk_s2_ff && !kclk_s3_ff;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			kclk_s1_ff <= 1'b0;
			kclk_s2_ff <= 1'b0;
			kclk_s3_ff <= 1'b0;
			kd_s1_ff <= 1'b0;
			kd_s2_ff <= 1'b0;
			key_ff <= KEY_RST;
		end else begin
			kclk_s1_ff <= key_clk;
			kclk_s2_ff <= kclk_s1_ff;
			kclk_s3_ff <= kclk_s2_ff;
			kd_s1_ff <= key_in;
			kd_s2_ff <= kd_s1_ff;
			if (key_mode_req && kclk_rise) begin
				key_ff <= {key_ff[KEY_W-2:0], kd_s2_ff};
			end
		end
	end

	// PIN setup mode and inactivity lockout
	logic pin_mode_ff;
	logic locked_ff;
	logic [35:0] idle_ff;
	wire [35:0] tmo_lim = timer_sel ? TMO_LONG : TMO_SHORT;
	wire idle_exp = (idle_ff >= tmo_lim);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_mode_ff <= 1'b0;
			locked_ff <= 1'b0;
			idle_ff <= '0;
		end else begin
			if (pin_rise) begin
				pin_mode_ff <= 1'b1;
			end else if (pin_done) begin
				pin_mode_ff <= 1'b0;
			end
			if (send_s2_ff || pin_mode_ff) begin
				idle_ff <= '0;
			end else if (!idle_exp) begin
				idle_ff <= idle_ff + 36'h1;
			end
			if (idle_exp) begin
				locked_ff <= 1'b1;
			end else if (pin_done) begin
				locked_ff <= 1'b0;
			end
		end
	end

	// Packet builder: buttons captured on the rise, counter steps per packet
	logic [7:0] btn_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic pkt_req_ff;
	logic [BLOCK_W-1:0] blk_data;
	logic blk_ready;
	wire [CHK_W-1:0] chk = {key_ff[CHK_W-1:0]} ^ {CHK_W{^{btn_ff, cnt_ff}}};
	wire [BLOCK_W-1:0] plain = {btn_ff, cnt_ff, chk};
	wire [BLOCK_W-1:0] cipher = plain ^ {key_ff[47:0], key_ff};
	wire push = pkt_req_ff && blk_ready;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			btn_ff <= 8'h00;
			cnt_ff <= CNT_RST;
			pkt_req_ff <= 1'b0;
		end else begin
			if (send_rise) begin
				btn_ff <= button_inputs;
			end
			pkt_req_ff <= send_s2_ff && !locked_ff;
			if (push) begin
				cnt_ff <= cnt_ff - 40'h1;
			end
		end
	end
	assign blk_data = cipher;

	// Packet FIFO between builder and serialiser
	logic [BLOCK_W-1:0] q_data;
	logic q_valid;
	logic q_ready;
	rce_fifo #(.WIDTH(BLOCK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.in_data(blk_data),
		.in_valid(pkt_req_ff),
		.in_ready(blk_ready),
		.out_data(q_data),
		.out_valid(q_valid),
		.out_ready(q_ready)
	);

	// Serialiser state machine
	rce_state_t st_ff, nxt_st;
	logic [BLOCK_W-1:0] sh_ff;
	logic [13:0] baud_ff;
	logic [6:0] bit_ff;
	logic dout_ff;
	wire bit_end = (baud_ff == bit_div - 14'h1);
	assign q_ready = (st_ff == RCE_LOAD);
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			RCE_IDLE: if (q_valid) nxt_st = RCE_LOAD;
			RCE_LOAD: nxt_st = RCE_SHIFT;
			RCE_SHIFT: if (bit_end && bit_ff == LAST_BIT) nxt_st = RCE_IDLE;
			default: nxt_st = RCE_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= RCE_IDLE;
			sh_ff <= '0;
			baud_ff <= 14'h0;
			bit_ff <= 7'h0;
			dout_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			if (st_ff == RCE_LOAD) begin
				sh_ff <= q_data;
				baud_ff <= 14'h0;
				bit_ff <= 7'h0;
				dout_ff <= q_data[BLOCK_W-1];
			end else if (st_ff == RCE_SHIFT) begin
				baud_ff <= bit_end ? 14'h0 : baud_ff + 14'h1;
				if (bit_end) begin
					sh_ff <= {sh_ff[BLOCK_W-2:0], 1'b0};
					bit_ff <= bit_ff + 7'h1;
					dout_ff <= (bit_ff == LAST_BIT) ? 1'b0 : sh_ff[BLOCK_W-2];
				end
			end else begin
				dout_ff <= 1'b0;
			end
		end
	end

	// Output registers
	logic txp_ff, mode_ff, lock_o_ff;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			txp_ff <= 1'b0;
			mode_ff <= 1'b0;
			lock_o_ff <= 1'b0;
		end else begin
			txp_ff <= send_s2_ff;
			mode_ff <= key_mode_req || pin_mode_ff;
			lock_o_ff <= locked_ff;
		end
	end
	assign transmitter_power_ctl = txp_ff;
	assign serial_data_out = dout_ff;
	assign mode_indicator_out = mode_ff;
	assign pin_locked = lock_o_ff;

	// Checks on outputs and control, one label per guarded behaviour
	a_power_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
		txp_ff == $past(send_s2_ff)) else $error("power ctl not following request");
	a_button_cap: assert property (@(posedge sys_clk) disable iff (!reset_n)
		send_rise |=> btn_ff == $past(button_inputs)) else $error("buttons not captured");
	a_rate_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rate_done_ff && $past(rate_done_ff) |-> $stable(rate_fast_ff)) else $error("rate moved");
	a_rate_div: assert property (@(posedge sys_clk) disable iff (!reset_n)
		bit_div == (rate_fast_ff ? 14'h6c8 : 14'h28b0)) else $error("bad divider");
	a_mode_indicator_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(key_mode_req || pin_mode_ff) |=> mode_ff) else $error("mode_indicator_out low");
	a_pin_enter: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pin_rise |=> pin_mode_ff) else $error("pin mode not entered");
	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st_ff == RCE_IDLE |=> !dout_ff) else $error("output not quiet");
	a_count_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
		push |=> cnt_ff == $past(cnt_ff) - 40'h1) else $error("counter not stepped");
	a_sync_edge: assert property (@(posedge sys_clk) disable iff (!reset_n)
		send_rise |-> $past(send_req, 2) && !$past(send_req, 3)) else $error("bad edge");
	// Indicator stays dark outside both modes
	a_mode_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!(key_mode_req || pin_mode_ff) |=> !mode_ff) else $error("mode_indicator_out high");
	// Held request keeps the queue fed while unlocked
	a_pkt_repeat: assert property (@(posedge sys_clk) disable iff (!reset_n)
		send_s2_ff && !locked_ff |=> pkt_req_ff) else $error("packet request dropped");
	// Captured buttons only move on a request rise
	a_btn_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!send_rise |=> $stable(btn_ff)) else $error("buttons moved");
	// Each key clock rise in key mode shifts in the synchronised key bit
	a_key_shift: assert property (@(posedge sys_clk) disable iff (!reset_n)
		key_mode_req && kclk_rise |=> key_ff[0] == $past(kd_s2_ff)) else $error("key bit lost");

	// Lockout: an expired idle count locks, and a locked encoder queues nothing
	a_lock_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
		idle_exp |=> locked_ff) else $error("lock not set");
	a_lock_block: assert property (@(posedge sys_clk) disable iff (!reset_n)
		locked_ff |=> !pkt_req_ff) else $error("packet queued while locked");

	// Serialiser steps as named sequences
	// A block is taken from the queue in the load state
	sequence s_pkt_load;
		st_ff == RCE_LOAD;
	endsequence
	// Shifting starts with a fresh bit period at bit zero
	sequence s_first_bit;
		st_ff == RCE_SHIFT && baud_ff == 14'h0 && bit_ff == 7'h0;
	endsequence
	// Inside a bit period, before its last cycle
	sequence s_mid_bit;
		st_ff == RCE_SHIFT && !bit_end;
	endsequence
	// Last cycle of the last bit of a block
	sequence s_last_bit;
		st_ff == RCE_SHIFT && bit_end && bit_ff == LAST_BIT;
	endsequence
	// Back in idle with the line low
	sequence s_line_quiet;
		st_ff == RCE_IDLE && !dout_ff;
	endsequence

	// A popped block starts shifting at once, top bit first
	a_load_shift: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_pkt_load |=> s_first_bit) else $error("load did not start shifting");
	a_first_msb: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_pkt_load |=> dout_ff == $past(q_data[BLOCK_W-1])) else $error("first bit not msb");
	// A bit stands for the whole divider period
	a_bit_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_mid_bit |=> $stable(dout_ff)) else $error("bit changed mid period");
	a_baud_range: assert property (@(posedge sys_clk) disable iff (!reset_n)
		st_ff == RCE_SHIFT |-> baud_ff < bit_div) else $error("baud count overran");
	// After the last block bit the line falls quiet again
	a_pkt_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_last_bit |=> s_line_quiet) else $error("packet length wrong");
endmodule : rce_encoder

// ==== rce_pkg.sv ====
// Shared constants for the remote control encoder pin logic
package rce_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned BAUD_FAST = 28800;
	localparam int unsigned BAUD_SLOW = 4800;
	// Bit periods in clock cycles, rounded down
	localparam int unsigned FAST_DIV_I = CLK_HZ / BAUD_FAST;
	localparam int unsigned SLOW_DIV_I = CLK_HZ / BAUD_SLOW;
	localparam logic [13:0] FAST_DIV = 14'(FAST_DIV_I);
	localparam logic [13:0] SLOW_DIV = 14'(SLOW_DIV_I);
	// Packet layout
	localparam int unsigned BTN_W = 8;
	localparam int unsigned CNT_W = 40;
	localparam int unsigned BLOCK_W = 128;
	localparam int unsigned CHK_W = BLOCK_W - BTN_W - CNT_W;
	localparam logic [39:0] CNT_RST = 40'hff_ffff_ffff;
	localparam logic [79:0] KEY_RST = 80'h0;
	localparam int unsigned KEY_W = 80;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [6:0] LAST_BIT = 7'h7f;
	localparam logic [6:0] KEY_LAST = 7'h4f;
	// Inactivity timeouts in seconds and in cycles
	localparam int unsigned TMO_SHORT_S = 30;
	localparam int unsigned TMO_LONG_S = 300;
	localparam logic [35:0] TMO_SHORT = 36'(64'(TMO_SHORT_S) * 64'(CLK_HZ));
	localparam logic [35:0] TMO_LONG = 36'(64'(TMO_LONG_S) * 64'(CLK_HZ));
	// Transmit state machine, one-hot
	typedef enum logic [2:0] {
		RCE_IDLE = 3'h1,
		RCE_LOAD = 3'h2,
		RCE_SHIFT = 3'h4
	} rce_state_t;
endpackage : rce_pkg

// ==== rce_fifo.sv ====
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module rce_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	// Honest full and empty from the occupancy count
	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	// Storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
	// Pointers and count
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
			if (pop) rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : rce_fifo

// ==== rce_rf_model.sv ====
// Behavioural radio transmitter model that samples the encoder serial stream
`timescale 1ns/1ps
module rce_rf_model (
	input wire logic sys_clk,
	input wire logic powered,
	input wire logic rf_data,
	input wire logic [13:0] bit_div,
	input wire logic [3:0] want_bits,
	output logic [7:0] rx_bits,
	output logic [3:0] rx_count
);
	// Nothing heard before power; each power-up skips to the first bit,
	// then samples each bit near its middle
	initial begin
		rx_bits = 8'h00;
		rx_count = 4'h0;
		forever begin
			@(posedge powered);
			rx_count = 4'h0;
			repeat (4 + bit_div / 2) @(posedge sys_clk);
			// Only a powered transmitter hears data
			while (rx_count < want_bits && powered) begin
				rx_bits = {rx_bits[6:0], rf_data};
				rx_count = rx_count + 4'h1;
				// Stop waiting once the last wanted bit is in or power drops,
				// so the next power-up is never missed
				for (int i = 0; i < bit_div && powered && rx_count < want_bits; i++) begin
					@(posedge sys_clk);
				end
			end
		end
	end
endmodule : rce_rf_model

// ==== remote_encoder_pin_control_tb.sv ====
// Self-checking bench for the encoder pin control logic
`timescale 1ns/1ps
module remote_encoder_pin_control_tb
	import rce_pkg::*;
;
	// Every input starts at a defined level
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] button_inputs = 8'h00;
	logic send_req = 1'b0;
	logic rate_sel = 1'b1;
	logic timer_sel = 1'b0;
	logic key_in = 1'b0;
	logic key_clk = 1'b0;
	logic key_mode_req = 1'b0;
	logic pin_create_req = 1'b0;
	logic pin_done = 1'b0;
	logic [13:0] bit_div = FAST_DIV;
	logic [3:0] want_bits = 4'h8;
	logic transmitter_power_ctl, serial_data_out, mode_indicator_out, pin_locked;
	logic [7:0] rx_bits;
	logic [3:0] rx_count;
	logic [7:0] btn;
	int n_errors = 0;
	int checks = 0;
	int cyc_cnt = 0;
	int seed;
	rce_encoder u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .button_inputs(button_inputs),
		.send_req(send_req), .rate_sel(rate_sel), .timer_sel(timer_sel), .key_in(key_in),
		.key_clk(key_clk), .key_mode_req(key_mode_req), .pin_create_req(pin_create_req),
		.pin_done(pin_done), .transmitter_power_ctl(transmitter_power_ctl),
		.serial_data_out(serial_data_out), .mode_indicator_out(mode_indicator_out),
		.pin_locked(pin_locked));
	rce_rf_model u_rf (.sys_clk(sys_clk), .powered(transmitter_power_ctl),
		.rf_data(serial_data_out), .bit_div(bit_div), .want_bits(want_bits),
		.rx_bits(rx_bits), .rx_count(rx_count));
	// Clock at 50 MHz
	always #10 sys_clk = ~sys_clk;
	// Hang guard
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 80000) begin
			n_errors++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end
	// Leading bits of the button byte, as sent most significant first
	function automatic logic [7:0] head_bits(input logic [7:0] b, input int n);
		return b >> (8 - n);
	endfunction : head_bits
	// Advance n edges, then drive just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : step
	task automatic chk1(input string what, input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk1
	task automatic chk8(input string what, input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8
	// Bounded wait for the model to hear n bits
	task automatic wait_rx(input logic [3:0] n);
		want_bits = n;
		for (int i = 0; i < 30000 && rx_count !== n; i++) step(1);
	endtask : wait_rx
	// Reset with a chosen rate, then flip the rate pin afterwards
	task automatic do_reset(input logic rs);
		reset_n = 1'b0;
		rate_sel = rs;
		send_req = 1'b0;
		step(10);
		reset_n = 1'b1;
		step(2);
		rate_sel = ~rs;
		chk1("power idle", transmitter_power_ctl, 1'b0);
		chk1("data idle", serial_data_out, 1'b0);
		chk1("mode idle", mode_indicator_out, 1'b0);
	endtask : do_reset
	// Send one burst and check the leading bits heard by the radio
	task automatic burst(input logic [3:0] n);
		btn = 8'($urandom);
		button_inputs = btn;
		timer_sel = 1'($urandom);
		send_req = 1'b1;
		step(1);
		chk1("power early", transmitter_power_ctl, 1'b0);
		step(3);
		chk1("power on", transmitter_power_ctl, 1'b1);
		button_inputs = ~btn;
		wait_rx(n);
		chk8("bits", {4'h0, rx_count}, {4'h0, n});
		chk8("payload", rx_bits & ~(8'hff << n), head_bits(btn, n));
		send_req = 1'b0;
		step(4);
		chk1("power off", transmitter_power_ctl, 1'b0);
	endtask : burst
	task automatic end_of_test();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		seed = $urandom(12);
		do_reset(1'b1);
		burst(4'h8);
		$display("test fast_packet done");
		// Key learning mode with random serial key bits
		key_mode_req = 1'b1;
		for (int i = 0; i < 16; i++) begin
			key_in = 1'($urandom);
			key_clk = ~key_clk;
			step(3);
		end
		chk1("key mode", mode_indicator_out, 1'b1);
		key_mode_req = 1'b0;
		step(4);
		chk1("key left", mode_indicator_out, 1'b0);
		pin_create_req = 1'b1;
		step(5);
		pin_create_req = 1'b0;
		step(2);
		chk1("pin mode", mode_indicator_out, 1'b1);
		pin_done = 1'b1;
		step(4);
		chk1("pin left", mode_indicator_out, 1'b0);
		chk1("unlocked", pin_locked, 1'b0);
		pin_done = 1'b0;
		$display("test modes done");
		bit_div = SLOW_DIV;
		do_reset(1'b0);
		burst(4'h2);
		$display("test slow_packet done");
		end_of_test();
	end
endmodule : remote_encoder_pin_control_tb
